// ---- ipr_regs.sv ----
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module ipr_regs (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [5:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [5:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output ipr_pkg::ipr_prio_t prio_out,
   output logic [15:0] src_enable_out
);
   function automatic logic [2:0] reg_idx(input logic [5:0] a);
      reg_idx = a[4:2];
   endfunction
   function automatic logic addr_ok(input logic [5:0] a);
      addr_ok = (a[5] == 1'b0) && (a[1:0] == 2'h0);
   endfunction
   function automatic logic [15:0] reg_mask(input logic [2:0] i);
      unique case (i)
         3'h0: reg_mask = ipr_pkg::MASK_PC10;
         3'h1: reg_mask = ipr_pkg::MASK_PC11;
         3'h2: reg_mask = ipr_pkg::MASK_PC12;
         3'h3: reg_mask = ipr_pkg::MASK_PC13;
         3'h4: reg_mask = ipr_pkg::MASK_PC15;
         3'h5: reg_mask = ipr_pkg::MASK_PC16;
         3'h6: reg_mask = ipr_pkg::MASK_PC18;
         3'h7: reg_mask = ipr_pkg::MASK_PC19;
      endcase
   endfunction
   function automatic logic [15:0] reg_rst(input logic [2:0] i);
      unique case (i)
         3'h0: reg_rst = ipr_pkg::RST_PC10;
         3'h1: reg_rst = ipr_pkg::RST_PC11;
         3'h2: reg_rst = ipr_pkg::RST_PC12;
         3'h3: reg_rst = ipr_pkg::RST_PC13;
         3'h4: reg_rst = ipr_pkg::RST_PC15;
         3'h5: reg_rst = ipr_pkg::RST_PC16;
         3'h6: reg_rst = ipr_pkg::RST_PC18;
         3'h7: reg_rst = ipr_pkg::RST_PC19;
      endcase
   endfunction
   function automatic logic [2:0] fld(input logic [15:0] r,
                                      input int unsigned lsb);
      fld = r[lsb +: 3];
   endfunction
   // a source is enabled whenever its code is not 000
   function automatic logic live(input logic [2:0] p);
      live = (p != ipr_pkg::PRIO_OFF);
   endfunction

   logic [15:0] regs_r [ipr_pkg::NREG];
   logic [5:0] aw_addr_r;
   logic aw_have_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic w_have_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   ipr_pkg::ipr_prio_t prio_r;
   logic [15:0] en_r;
   logic awready_r;
   logic wready_r;
   logic arready_r;
   logic run_prev_r;

   wire aw_take = s_axi_awvalid_in && awready_r;
   wire w_take = s_axi_wvalid_in && wready_r;
   wire do_write = aw_have_r && w_have_r && !bvalid_r;
   wire [2:0] w_idx = reg_idx(aw_addr_r);
   wire w_ok = addr_ok(aw_addr_r);
   wire [15:0] lane_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
   wire [15:0] w_bits = lane_mask & reg_mask(w_idx);
   wire ar_take = s_axi_arvalid_in && arready_r;
   wire [2:0] r_idx = reg_idx(s_axi_araddr_in);
   wire r_ok = addr_ok(s_axi_araddr_in);
   wire [15:0] r_word = regs_r[r_idx] & reg_mask(r_idx);

   // readies are flops, so their next state is worked out here
   wire aw_full_nxt = !do_write && (aw_have_r || aw_take);
   wire w_full_nxt = !do_write && (w_have_r || w_take);
   wire b_busy_nxt = do_write || (bvalid_r && !s_axi_bready_in);
   wire r_busy_nxt = ar_take || (rvalid_r && !s_axi_rready_in);

   // write path: aw and w latch independently, response after both
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 6'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= ipr_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr_in;
         end
         if (w_take) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata_in;
            w_strb_r <= s_axi_wstrb_in;
         end
         if (do_write) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= w_ok ? ipr_pkg::RESP_OKAY : ipr_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready_in) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      for (int i = 0; i < ipr_pkg::NREG; i++) begin
         if (rst_in) begin
            regs_r[i] <= reg_rst(3'(i));
         end else if (do_write && w_ok && (w_idx == 3'(i))) begin
            regs_r[i] <= (regs_r[i] & ~w_bits) |
                         (w_data_r[15:0] & w_bits);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rvalid_r <= 1'b0;
         rresp_r <= ipr_pkg::RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rresp_r <= r_ok ? ipr_pkg::RESP_OKAY : ipr_pkg::RESP_SLVERR;
         rdata_r <= r_ok ? {16'h0000, r_word} : 32'h0000_0000;
      end else if (rvalid_r && s_axi_rready_in) begin
         rvalid_r <= 1'b0;
      end
   end

   // ready flags one edge ahead, so bus outputs come from flops
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         arready_r <= 1'b1;
      end else begin
         awready_r <= !aw_full_nxt && !b_busy_nxt;
         wready_r <= !w_full_nxt && !b_busy_nxt;
         arready_r <= !r_busy_nxt;
      end
   end

   // assertion helper: high when the previous edge was out of reset
   always_ff @(posedge clk_in) begin
      run_prev_r <= !rst_in;
   end

   // field extraction; registered so outputs trail regs by one cycle
   ipr_pkg::ipr_prio_t prio_nxt;
   assign prio_nxt.compare7 = fld(regs_r[0], ipr_pkg::LSB_HI);
   assign prio_nxt.compare6 = fld(regs_r[0], ipr_pkg::LSB_MH);
   assign prio_nxt.compare5 = fld(regs_r[0], ipr_pkg::LSB_ML);
   assign prio_nxt.capture6 = fld(regs_r[0], ipr_pkg::LSB_LO);
   assign prio_nxt.parallel_port =
      fld(regs_r[1], ipr_pkg::LSB_ML);
   assign prio_nxt.compare8 = fld(regs_r[1], ipr_pkg::LSB_LO);
   assign prio_nxt.i2c2_master =
      fld(regs_r[2], ipr_pkg::LSB_MH);
   assign prio_nxt.i2c2_slave = fld(regs_r[2], ipr_pkg::LSB_ML);
   assign prio_nxt.ext_irq4 = fld(regs_r[3], ipr_pkg::LSB_MH);
   assign prio_nxt.ext_irq3 = fld(regs_r[3], ipr_pkg::LSB_ML);
   assign prio_nxt.calendar_clock =
      fld(regs_r[4], ipr_pkg::LSB_MH);
   assign prio_nxt.checksum_error =
      fld(regs_r[5], ipr_pkg::LSB_HI);
   assign prio_nxt.uart2_error =
      fld(regs_r[5], ipr_pkg::LSB_MH);
   assign prio_nxt.uart1_error =
      fld(regs_r[5], ipr_pkg::LSB_ML);
   assign prio_nxt.low_voltage =
      fld(regs_r[6], ipr_pkg::LSB_LO);
   assign prio_nxt.charge_time_unit =
      fld(regs_r[7], ipr_pkg::LSB_ML);

   // codes 001..111 pass straight through as levels 1..7
   logic [15:0] en_nxt;
   always_comb begin
      for (int k = 0; k < 16; k++) begin
         en_nxt[k] = live(prio_nxt[3*k +: 3]);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prio_r <= {16{ipr_pkg::PRIO_RESET}};
         en_r <= 16'hFFFF;
      end else begin
         prio_r <= prio_nxt;
         en_r <= en_nxt;
      end
   end

   assign s_axi_awready_out = awready_r;
   assign s_axi_wready_out = wready_r;
   assign s_axi_bvalid_out = bvalid_r;
   assign s_axi_bresp_out = bresp_r;
   assign s_axi_arready_out = arready_r;
   assign s_axi_rvalid_out = rvalid_r;
   assign s_axi_rresp_out = rresp_r;
   assign s_axi_rdata_out = rdata_r;
   assign prio_out = prio_r;
   assign src_enable_out = en_r;

   a_read_unimpl_zero: assert property (
      @(posedge clk_in) disable iff (rst_in) (ar_take && r_ok) |=>
      (rdata_r[15:0] & ~reg_mask($past(r_idx))) == 16'h0000 &&
      rdata_r[31:16] == 16'h0000)
      else $error("unimplemented bits read nonzero");
   a_read_bad_zero: assert property (
      @(posedge clk_in) disable iff (rst_in) (ar_take && !r_ok) |=>
      rdata_r == 32'h0000_0000 && rresp_r == ipr_pkg::RESP_SLVERR)
      else $error("bad read address returned data");
   a_reset_prio_four: assert property (
      @(posedge clk_in) rst_in |=>
      prio_r == {16{ipr_pkg::PRIO_RESET}} && en_r == 16'hFFFF)
      else $error("priority not four after reset");
   a_reset_regs: assert property (
      @(posedge clk_in) rst_in |=>
      regs_r[0] == ipr_pkg::RST_PC10 && regs_r[7] == ipr_pkg::RST_PC19)
      else $error("register not at reset value");
   a_disable_zero: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (prio_r.low_voltage == ipr_pkg::PRIO_OFF) |-> !en_r[1])
      else $error("zero priority left source enabled");
   a_enable_min: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (prio_r.compare8 >= ipr_pkg::PRIO_MIN) |-> en_r[10])
      else $error("nonzero priority not enabled");
   a_reg10_top: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.compare7 == $past(regs_r[0][ipr_pkg::LSB_HI +: 3]))
      else $error("compare7 field misplaced");
   a_fld_compare6: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.compare6 == $past(regs_r[0][ipr_pkg::LSB_MH +: 3]))
      else $error("compare6 field misplaced");
   a_fld_compare5: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.compare5 == $past(regs_r[0][ipr_pkg::LSB_ML +: 3]))
      else $error("compare5 field misplaced");
   a_fld_capture6: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.capture6 == $past(regs_r[0][ipr_pkg::LSB_LO +: 3]))
      else $error("capture6 field misplaced");
   a_fld_parallel: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.parallel_port == $past(regs_r[1][ipr_pkg::LSB_ML +: 3]))
      else $error("parallel port field misplaced");
   a_fld_compare8: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.compare8 == $past(regs_r[1][ipr_pkg::LSB_LO +: 3]))
      else $error("compare8 field misplaced");
   a_fld_i2c_master: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.i2c2_master == $past(regs_r[2][ipr_pkg::LSB_MH +: 3]))
      else $error("i2c2 master field misplaced");
   a_fld_i2c_slave: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.i2c2_slave == $past(regs_r[2][ipr_pkg::LSB_ML +: 3]))
      else $error("i2c2 slave field misplaced");
   a_fld_ext_four: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.ext_irq4 == $past(regs_r[3][ipr_pkg::LSB_MH +: 3]))
      else $error("external irq 4 field misplaced");
   a_fld_ext_three: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.ext_irq3 == $past(regs_r[3][ipr_pkg::LSB_ML +: 3]))
      else $error("external irq 3 field misplaced");
   a_fld_calendar: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.calendar_clock == $past(regs_r[4][ipr_pkg::LSB_MH +: 3]))
      else $error("calendar clock field misplaced");
   a_fld_checksum: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.checksum_error == $past(regs_r[5][ipr_pkg::LSB_HI +: 3]))
      else $error("checksum error field misplaced");
   a_fld_uart2_err: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.uart2_error == $past(regs_r[5][ipr_pkg::LSB_MH +: 3]))
      else $error("uart2 error field misplaced");
   a_fld_uart1_err: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.uart1_error == $past(regs_r[5][ipr_pkg::LSB_ML +: 3]))
      else $error("uart1 error field misplaced");
   a_fld_low_volt: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.low_voltage == $past(regs_r[6][ipr_pkg::LSB_LO +: 3]))
      else $error("low voltage field misplaced");
   a_fld_charge_time: assert property (
      @(posedge clk_in) disable iff (rst_in) run_prev_r |->
      prio_r.charge_time_unit == $past(regs_r[7][ipr_pkg::LSB_ML +: 3]))
      else $error("charge time field misplaced");
   a_write_lands: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (do_write && w_ok && w_idx == 3'h5 && w_strb_r[1]) |=> ##1
      prio_r.checksum_error == $past(w_data_r[ipr_pkg::LSB_HI +: 3], 2))
      else $error("checksum field write lost");
   a_max_level: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (prio_nxt.uart1_error == ipr_pkg::PRIO_MAX) |=>
      (prio_r.uart1_error == ipr_pkg::PRIO_MAX) && en_r[2])
      else $error("level seven not passed");
   a_bresp_after: assert property (
      @(posedge clk_in) disable iff (rst_in)
      do_write |=> bvalid_r)
      else $error("write response missing");
   a_lane_kept: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (do_write && w_idx == 3'h0 && !w_strb_r[1]) |=>
      $stable(regs_r[0][15:8]))
      else $error("unselected byte lane changed");
   a_bad_no_write: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (do_write && !w_ok && w_idx == 3'h0) |=> $stable(regs_r[0]))
      else $error("refused write changed a register");
   a_bad_write_err: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (do_write && !w_ok) |=> bresp_r == ipr_pkg::RESP_SLVERR)
      else $error("bad write address not refused");
   a_aw_ready_match: assert property (
      @(posedge clk_in) disable iff (rst_in)
      awready_r == (!aw_have_r && !bvalid_r))
      else $error("write address ready out of step");
   a_w_ready_match: assert property (
      @(posedge clk_in) disable iff (rst_in)
      wready_r == (!w_have_r && !bvalid_r))
      else $error("write data ready out of step");
   a_ar_ready_match: assert property (
      @(posedge clk_in) disable iff (rst_in)
      arready_r == !rvalid_r)
      else $error("read address ready out of step");
endmodule

// ---- ipr_pkg.sv ----
package ipr_pkg;
   localparam int unsigned AW = 6;
   localparam logic [5:0] OFF_PC10 = 6'h00;
   localparam logic [5:0] OFF_PC11 = 6'h04;
   localparam logic [5:0] OFF_PC12 = 6'h08;
   localparam logic [5:0] OFF_PC13 = 6'h0C;
   localparam logic [5:0] OFF_PC15 = 6'h10;
   localparam logic [5:0] OFF_PC16 = 6'h14;
   localparam logic [5:0] OFF_PC18 = 6'h18;
   localparam logic [5:0] OFF_PC19 = 6'h1C;
   localparam int unsigned NREG = 8;
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] PRIO_OFF = 3'h0;
   localparam logic [2:0] PRIO_MAX = 3'h7;
   localparam logic [2:0] PRIO_MIN = 3'h1;
   // implemented bit masks per register, index order 10..19
   localparam logic [15:0] MASK_PC10 = 16'h7777;
   localparam logic [15:0] MASK_PC11 = 16'h0077;
   localparam logic [15:0] MASK_PC12 = 16'h0770;
   localparam logic [15:0] MASK_PC13 = 16'h0770;
   localparam logic [15:0] MASK_PC15 = 16'h0700;
   localparam logic [15:0] MASK_PC16 = 16'h7770;
   localparam logic [15:0] MASK_PC18 = 16'h0007;
   localparam logic [15:0] MASK_PC19 = 16'h0070;
   // every field resets to 100
   localparam logic [15:0] RST_PC10 = 16'h4444;
   localparam logic [15:0] RST_PC11 = 16'h0044;
   localparam logic [15:0] RST_PC12 = 16'h0440;
   localparam logic [15:0] RST_PC13 = 16'h0440;
   localparam logic [15:0] RST_PC15 = 16'h0400;
   localparam logic [15:0] RST_PC16 = 16'h4440;
   localparam logic [15:0] RST_PC18 = 16'h0004;
   localparam logic [15:0] RST_PC19 = 16'h0040;
   localparam int unsigned LSB_HI = 12;
   localparam int unsigned LSB_MH = 8;
   localparam int unsigned LSB_ML = 4;
   localparam int unsigned LSB_LO = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic [2:0] compare7;
      logic [2:0] compare6;
      logic [2:0] compare5;
      logic [2:0] capture6;
      logic [2:0] parallel_port;
      logic [2:0] compare8;
      logic [2:0] i2c2_master;
      logic [2:0] i2c2_slave;
      logic [2:0] ext_irq4;
      logic [2:0] ext_irq3;
      logic [2:0] calendar_clock;
      logic [2:0] checksum_error;
      logic [2:0] uart2_error;
      logic [2:0] uart1_error;
      logic [2:0] low_voltage;
      logic [2:0] charge_time_unit;
   } ipr_prio_t;
   typedef struct packed {
      logic [15:0] en;
   } ipr_en_t;
endpackage

// ---- ipr_regs_tb.sv ----
`timescale 1ns/1ns
module ipr_regs_tb;
   localparam int LIMIT = 20000;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [5:0] awaddr = 6'h00;
   logic [5:0] araddr = 6'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   ipr_pkg::ipr_prio_t prio;
   logic [15:0] src_en;
   logic [15:0] sh [8];
   logic [15:0] mask [8] = '{ipr_pkg::MASK_PC10, ipr_pkg::MASK_PC11,
      ipr_pkg::MASK_PC12, ipr_pkg::MASK_PC13, ipr_pkg::MASK_PC15,
      ipr_pkg::MASK_PC16, ipr_pkg::MASK_PC18, ipr_pkg::MASK_PC19};
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;

   ipr_regs ipr_regs_i (.clk_in(clk_in), .rst_in(rst_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .prio_out(prio), .src_enable_out(src_en));

   always #5 clk_in = ~clk_in;

   task automatic print_verdict;
      if (n_fail == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // a hung handshake ends here rather than running forever
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic chk_data(logic [31:0] got, logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_prio(ipr_pkg::ipr_prio_t got,
                           ipr_pkg::ipr_prio_t exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic ipr_pkg::ipr_prio_t exp_prio();
      ipr_pkg::ipr_prio_t p;
      p.compare7 = sh[0][14:12];
      p.compare6 = sh[0][10:8];
      p.compare5 = sh[0][6:4];
      p.capture6 = sh[0][2:0];
      p.parallel_port = sh[1][6:4];
      p.compare8 = sh[1][2:0];
      p.i2c2_master = sh[2][10:8];
      p.i2c2_slave = sh[2][6:4];
      p.ext_irq4 = sh[3][10:8];
      p.ext_irq3 = sh[3][6:4];
      p.calendar_clock = sh[4][10:8];
      p.checksum_error = sh[5][14:12];
      p.uart2_error = sh[5][10:8];
      p.uart1_error = sh[5][6:4];
      p.low_voltage = sh[6][2:0];
      p.charge_time_unit = sh[7][6:4];
      return p;
   endfunction

   function automatic logic [15:0] exp_en();
      logic [47:0] p;
      logic [15:0] e;
      p = exp_prio();
      for (int k = 0; k < 16; k++)
         e[k] = |p[3*k +: 3];
      return e;
   endfunction

   // aw and w may be taken at different edges, so each has its own flag
   task automatic wr(logic [5:0] a, logic [31:0] d, logic [3:0] s,
                     logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk_in);
         if (awvalid && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_in); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk_data(32'(bresp), 32'(er));
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_in); while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask

   task automatic check_all;
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 8; i++) begin
         rd(6'(i * 4), d, r);
         chk_data(d, {16'h0000, sh[i]});
         chk_data(32'(r), 32'(ipr_pkg::RESP_OKAY));
      end
      chk_prio(prio, exp_prio());
      chk_data(32'(src_en), 32'(exp_en()));
   endtask

   task automatic t_reset;
      for (int i = 0; i < 8; i++)
         sh[i] = 16'h4444 & mask[i];
      check_all();
   endtask

   task automatic t_fill(logic [31:0] d);
      for (int i = 0; i < 8; i++) begin
         wr(6'(i * 4), d, 4'hF, ipr_pkg::RESP_OKAY);
         sh[i] = d[15:0] & mask[i];
      end
      check_all();
   endtask

   // one byte lane at a time must leave the other lane alone
   task automatic t_strobe;
      wr(6'h00, 32'h0000_6655, 4'h1, ipr_pkg::RESP_OKAY);
      sh[0][7:0] = 8'h55 & mask[0][7:0];
      check_all();
      wr(6'h00, 32'h0000_7700, 4'h2, ipr_pkg::RESP_OKAY);
      sh[0][15:8] = 8'h77 & mask[0][15:8];
      check_all();
   endtask

   task automatic t_bad;
      logic [31:0] d;
      logic [1:0] r;
      wr(6'h20, 32'h0000_0000, 4'hF, ipr_pkg::RESP_SLVERR);
      wr(6'h02, 32'h0000_0000, 4'hF, ipr_pkg::RESP_SLVERR);
      rd(6'h3C, d, r);
      chk_data(d, 32'h0000_0000);
      chk_data(32'(r), 32'(ipr_pkg::RESP_SLVERR));
      check_all();
   endtask

   initial begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_fill(32'hFFFF_FFFF);
      t_fill(32'h0000_0000);
      t_fill(32'h1111_1111);
      t_fill(32'hA5A5_1234);
      t_strobe();
      t_bad();
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset();
      print_verdict();
   end
endmodule
